// *** pkg/ers_map.svh ***
// Encodings, field positions and field values for the selected error status register
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH
`define ERS_OP0 2'h3
`define ERS_OP1 3'h0
`define ERS_CRN 4'h5
`define ERS_CRM 4'h4
`define ERS_OP2 3'h2
`define ERS_EC_SYSREG 6'h18
`define ERS_BIT_AV 31
`define ERS_BIT_V 30
`define ERS_BIT_UE 29
`define ERS_BIT_ER 28
`define ERS_BIT_OF 27
`define ERS_BIT_MV 26
`define ERS_CE_HI 25
`define ERS_CE_LO 24
`define ERS_BIT_DE 23
`define ERS_BIT_PN 22
`define ERS_UET_HI 21
`define ERS_UET_LO 20
`define ERS_PRIMARY_ERROR_CODE_HI 4
`define ERS_PRIMARY_ERROR_CODE_LO 0
`define ERS_CE_NONE 2'h0
`define ERS_CE_TRANSIENT 2'h1
`define ERS_CE_ANY 2'h2
`define ERS_CE_ALL 2'h3
`define ERS_UET_UC 2'h0
`define ERS_PN_VALUE 1'h0
`define ERS_PRIMARY_ERROR_CODE_NONE 5'h00
`define ERS_PRIMARY_ERROR_CODE_BUF_ECC 5'h02
`define ERS_PRIMARY_ERROR_CODE_DATA_ECC 5'h06
`define ERS_PRIMARY_ERROR_CODE_TAG_ECC 5'h07
`define ERS_PRIMARY_ERROR_CODE_TLB_PAR 5'h08
`define ERS_PRIMARY_ERROR_CODE_COPYBACK 5'h12
`define ERS_PRIMARY_ERROR_CODE_DEFER_SLV 5'h15
`define ERS_LVL_USER 2'h0
`define ERS_LVL_KERNEL 2'h1
`define ERS_LVL_HYP 2'h2
`define ERS_LVL_MON 2'h3
`endif

// *** pkg/ers_pkg.sv ***
// Types for the selected error status register block
package ers_pkg;
  typedef enum logic [3:0] {
    ERS_OUT_OK = 4'h1,
    ERS_OUT_UNDEF = 4'h2,
    ERS_OUT_TRAP_HYP = 4'h4,
    ERS_OUT_TRAP_MON = 4'h8
  } ers_outcome_t;
  typedef struct packed {
    logic valid;
    logic uncorrected_flag;
    logic reported;
    logic overflow_flag;
    logic extra_syndrome_valid;
    logic [1:0] corrected_class;
    logic deferred_error_flag;
    logic [4:0] primary_error_code;
  } ers_record_t;
endpackage

// *** rtl/ers_access_check.sv ***
// Privilege and trap decision for one system-register access
`timescale 1ns/100ps
`include "ers_map.svh"
module ers_access_check (
  input wire logic [1:0] level,
  input wire logic is_write,
  input wire logic hyp_enabled,
  input wire logic hyp_error_register_trap,
  input wire logic mon_error_register_trap,
  input wire logic fine_grained_trap_enable,
  input wire logic fine_grained_read_trap,
  input wire logic fine_grained_write_trap,
  output ers_pkg::ers_outcome_t outcome
);
  logic fg_hit;
  // Fine-grained bit chosen by access direction
  always_comb begin
    fg_hit = is_write ? fine_grained_write_trap : fine_grained_read_trap;
    outcome = ers_pkg::ERS_OUT_OK;
    case (level)
      `ERS_LVL_USER: outcome = ers_pkg::ERS_OUT_UNDEF;
      `ERS_LVL_KERNEL: begin
        if (hyp_enabled && hyp_error_register_trap) begin
          outcome = ers_pkg::ERS_OUT_TRAP_HYP;
        end else if (hyp_enabled && fine_grained_trap_enable && fg_hit) begin
          outcome = ers_pkg::ERS_OUT_TRAP_HYP;
        end else if (mon_error_register_trap) begin
          outcome = ers_pkg::ERS_OUT_TRAP_MON;
        end
      end
      `ERS_LVL_HYP: begin
        if (mon_error_register_trap) begin
          outcome = ers_pkg::ERS_OUT_TRAP_MON;
        end
      end
      default: outcome = ers_pkg::ERS_OUT_OK;
    endcase
  end
endmodule

// *** rtl/ers_status.sv ***
// Selected error record status register bank with error capture and trap checks
`timescale 1ns/100ps
`include "ers_map.svh"
module ers_status #(
  parameter int NUM_RECORDS = 2,
  parameter int SEL_W = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [SEL_W-1:0] record_select,
  input wire logic sysreg_req,
  input wire logic sysreg_write,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [3:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  input wire logic [63:0] sysreg_wdata,
  input wire logic [1:0] level,
  input wire logic hyp_enabled,
  input wire logic hyp_error_register_trap,
  input wire logic mon_error_register_trap,
  input wire logic fine_grained_trap_enable,
  input wire logic fine_grained_read_trap,
  input wire logic fine_grained_write_trap,
  input wire logic [NUM_RECORDS-1:0] err_event,
  input wire logic [NUM_RECORDS-1:0] err_uncorrected,
  input wire logic [NUM_RECORDS-1:0] err_deferred,
  input wire logic [NUM_RECORDS-1:0] err_corrected,
  input wire logic [NUM_RECORDS-1:0] err_transient,
  input wire logic [NUM_RECORDS-1:0] err_reported,
  input wire logic [NUM_RECORDS-1:0] err_syndrome,
  input wire logic [NUM_RECORDS*5-1:0] err_code,
  output logic sysreg_ack,
  output logic [63:0] sysreg_rdata,
  output logic sysreg_undef,
  output logic sysreg_trap,
  output logic [1:0] sysreg_trap_level,
  output logic [5:0] sysreg_trap_class
);
  // Elaboration check: select must be able to name every record
  if (NUM_RECORDS < 1 || NUM_RECORDS > (1 << SEL_W)) begin : g_bad_params
    $error("ers_status: NUM_RECORDS does not fit SEL_W");
  end

  ers_pkg::ers_outcome_t outcome;
  logic hit;
  logic ack_d, ack_q;
  logic undef_d, undef_q;
  logic trap_d, trap_q;
  logic [1:0] trap_lvl_d, trap_lvl_q;
  logic [5:0] trap_cls_d, trap_cls_q;
  logic [63:0] rdata_d, rdata_q;
  ers_pkg::ers_record_t rec_q [NUM_RECORDS];
  ers_pkg::ers_record_t rec_d [NUM_RECORDS];
  ers_pkg::ers_record_t sel_rec;

  ers_access_check u_check (
    .level(level),
    .is_write(sysreg_write),
    .hyp_enabled(hyp_enabled),
    .hyp_error_register_trap(hyp_error_register_trap),
    .mon_error_register_trap(mon_error_register_trap),
    .fine_grained_trap_enable(fine_grained_trap_enable),
    .fine_grained_read_trap(fine_grained_read_trap),
    .fine_grained_write_trap(fine_grained_write_trap),
    .outcome(outcome)
  );

  // Encoding match; other encodings belong to sibling registers
  assign hit = sysreg_req && sysreg_op0 == `ERS_OP0 && sysreg_op1 == `ERS_OP1 &&
               sysreg_crn == `ERS_CRN && sysreg_crm == `ERS_CRM &&
               sysreg_op2 == `ERS_OP2;

  assign sel_rec = rec_q[record_select];

  // Per-record capture and clear; one lane per record
  for (genvar r = 0; r < NUM_RECORDS; r++) begin : g_rec
    logic wr;
    logic ev;
    logic [4:0] code;
    assign wr = hit && sysreg_write && outcome == ers_pkg::ERS_OUT_OK &&
                record_select == SEL_W'(r);
    assign ev = err_event[r];
    assign code = err_code[r*5 +: 5];
    always_comb begin
      rec_d[r] = rec_q[r];
      // Write-one-to-clear first so a same-cycle error overrides it
      if (wr) begin
        if (sysreg_wdata[`ERS_BIT_V]) begin
          rec_d[r].valid = 1'b0;
        end
        if (sysreg_wdata[`ERS_BIT_UE]) begin
          rec_d[r].uncorrected_flag = 1'b0;
        end
        if (sysreg_wdata[`ERS_BIT_ER]) begin
          rec_d[r].reported = 1'b0;
        end
        if (sysreg_wdata[`ERS_BIT_OF]) begin
          rec_d[r].overflow_flag = 1'b0;
        end
        if (sysreg_wdata[`ERS_BIT_MV]) begin
          rec_d[r].extra_syndrome_valid = 1'b0;
        end
        if (sysreg_wdata[`ERS_BIT_DE]) begin
          rec_d[r].deferred_error_flag = 1'b0;
        end
        // Mixed patterns are unknown by spec; clearing on any set bit is a safe pick
        if (sysreg_wdata[`ERS_CE_HI:`ERS_CE_LO] != `ERS_CE_NONE) begin
          rec_d[r].corrected_class = `ERS_CE_NONE;
        end
        if (sysreg_wdata[`ERS_BIT_V]) begin
          rec_d[r].primary_error_code = `ERS_PRIMARY_ERROR_CODE_NONE;
        end
      end
      // New error: sets win over a concurrent clear
      if (ev) begin
        // Judged after any same-cycle clear, so a freed record takes the error cleanly
        rec_d[r].overflow_flag = rec_d[r].valid || rec_d[r].overflow_flag;
        rec_d[r].valid = 1'b1;
        if (err_uncorrected[r]) begin
          rec_d[r].uncorrected_flag = 1'b1;
        end
        if (err_deferred[r]) begin
          rec_d[r].deferred_error_flag = 1'b1;
        end
        if (err_reported[r]) begin
          rec_d[r].reported = 1'b1;
        end
        if (err_syndrome[r]) begin
          rec_d[r].extra_syndrome_valid = 1'b1;
        end
        if (err_corrected[r]) begin
          // Transient only while no other correction class has been seen
          if (err_transient[r] && rec_d[r].corrected_class != `ERS_CE_ANY) begin
            rec_d[r].corrected_class = `ERS_CE_TRANSIENT;
          end else begin
            rec_d[r].corrected_class = `ERS_CE_ANY;
          end
        end
        // Keep the first code unless the record was free; drop the later one
        if (!rec_q[r].valid || (wr && sysreg_wdata[`ERS_BIT_V])) begin
          rec_d[r].primary_error_code = code;
        end
      end
    end
    // Only cold reset clears; warm reset is not wired here
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        rec_q[r] <= '0;
      end else begin
        rec_q[r] <= rec_d[r];
      end
    end
  end

  // Answer to an access: read data, undefined or trap report
  always_comb begin
    ack_d = hit;
    undef_d = 1'b0;
    trap_d = 1'b0;
    trap_lvl_d = `ERS_LVL_USER;
    trap_cls_d = 6'h00;
    rdata_d = 64'h0; // Reserved bits 63:32 and 19:5 stay zero
    if (hit) begin
      case (outcome)
        ers_pkg::ERS_OUT_UNDEF: undef_d = 1'b1;
        ers_pkg::ERS_OUT_TRAP_HYP: begin
          trap_d = 1'b1;
          trap_lvl_d = `ERS_LVL_HYP;
          trap_cls_d = `ERS_EC_SYSREG;
        end
        ers_pkg::ERS_OUT_TRAP_MON: begin
          trap_d = 1'b1;
          trap_lvl_d = `ERS_LVL_MON;
          trap_cls_d = `ERS_EC_SYSREG;
        end
        ers_pkg::ERS_OUT_OK: begin
          if (!sysreg_write) begin
            // Fields read as held even when valid is clear; software must ignore them
            rdata_d[`ERS_BIT_V] = sel_rec.valid;
            rdata_d[`ERS_BIT_UE] = sel_rec.uncorrected_flag;
            rdata_d[`ERS_BIT_ER] = sel_rec.reported;
            rdata_d[`ERS_BIT_OF] = sel_rec.overflow_flag;
            rdata_d[`ERS_BIT_MV] = sel_rec.extra_syndrome_valid;
            rdata_d[`ERS_CE_HI:`ERS_CE_LO] = sel_rec.corrected_class;
            rdata_d[`ERS_BIT_DE] = sel_rec.deferred_error_flag;
            rdata_d[`ERS_BIT_PN] = `ERS_PN_VALUE;
            rdata_d[`ERS_UET_HI:`ERS_UET_LO] = `ERS_UET_UC;
            rdata_d[`ERS_PRIMARY_ERROR_CODE_HI:`ERS_PRIMARY_ERROR_CODE_LO] = sel_rec.primary_error_code;
          end
        end
        default: undef_d = 1'b1;
      endcase
    end
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      undef_q <= 1'b0;
      trap_q <= 1'b0;
      trap_lvl_q <= `ERS_LVL_USER;
      trap_cls_q <= 6'h00;
      rdata_q <= 64'h0;
    end else begin
      ack_q <= ack_d;
      undef_q <= undef_d;
      trap_q <= trap_d;
      trap_lvl_q <= trap_lvl_d;
      trap_cls_q <= trap_cls_d;
      rdata_q <= rdata_d;
    end
  end

  assign sysreg_ack = ack_q;
  assign sysreg_undef = undef_q;
  assign sysreg_trap = trap_q;
  assign sysreg_trap_level = trap_lvl_q;
  assign sysreg_trap_class = trap_cls_q;
  assign sysreg_rdata = rdata_q;
endmodule

// *** test/ers_status_chk.sv ***
// Port-level assertions for the selected error status register
`timescale 1ns/100ps
module ers_status_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sysreg_req,
  input wire logic sysreg_write,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [3:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  input wire logic [1:0] level,
  input wire logic hyp_enabled,
  input wire logic hyp_error_register_trap,
  input wire logic mon_error_register_trap,
  input wire logic fine_grained_trap_enable,
  input wire logic fine_grained_read_trap,
  input wire logic fine_grained_write_trap,
  input wire logic sysreg_ack,
  input wire logic [63:0] sysreg_rdata,
  input wire logic sysreg_undef,
  input wire logic sysreg_trap,
  input wire logic [1:0] sysreg_trap_level
);
  logic hit;
  logic l1h;
  // Encoding 3,0,5,4,2 packed is c2a2; l1h is any level 1 hypervisor trap
  assign hit = sysreg_req &&
    {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm, sysreg_op2} == 16'hc2a2;
  assign l1h = level == 2'h1 && hyp_enabled && (hyp_error_register_trap ||
    fine_grained_trap_enable && (sysreg_write ? fine_grained_write_trap : fine_grained_read_trap));
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_ack; hit |=> sysreg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_miss; sysreg_req && !hit |=> !sysreg_ack; endproperty
  a_miss: assert property (p_miss) else $error("ack on miss");
  property p_undef; hit && level == 2'h0 |=> sysreg_undef && !sysreg_trap; endproperty
  a_undef: assert property (p_undef) else $error("no undef");
  property p_hyp;
    hit && level == 2'h1 && hyp_enabled && hyp_error_register_trap |=>
      sysreg_trap && sysreg_trap_level == 2'h2;
  endproperty
  a_hyp: assert property (p_hyp) else $error("no hyp trap");
  property p_fg; hit && l1h |=> sysreg_trap && sysreg_trap_level == 2'h2; endproperty
  a_fg: assert property (p_fg) else $error("no fine trap");
  property p_mon;
    hit && level inside {2'h1, 2'h2} && mon_error_register_trap && !l1h |=>
      sysreg_trap && sysreg_trap_level == 2'h3;
  endproperty
  a_mon: assert property (p_mon) else $error("no mon trap");
  property p_top; hit && level == 2'h3 |=> !sysreg_trap && !sysreg_undef; endproperty
  a_top: assert property (p_top) else $error("top level refused");
  property p_rsvd;
    sysreg_ack |-> sysreg_rdata[63:32] == 32'h0 && sysreg_rdata[22:5] == 18'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("fixed bits wrong");
  c_undef: cover property (sysreg_undef);
  c_mon: cover property (sysreg_trap && sysreg_trap_level == 2'h3);
  c_of: cover property (sysreg_ack && sysreg_rdata[27]);
endmodule
bind ers_status ers_status_chk u_ers_status_chk (.mclk(mclk), .reset(reset),
  .sysreg_req(sysreg_req), .sysreg_write(sysreg_write), .sysreg_op0(sysreg_op0),
  .sysreg_op1(sysreg_op1), .sysreg_crn(sysreg_crn), .sysreg_crm(sysreg_crm),
  .sysreg_op2(sysreg_op2), .level(level), .hyp_enabled(hyp_enabled),
  .hyp_error_register_trap(hyp_error_register_trap),
  .mon_error_register_trap(mon_error_register_trap),
  .fine_grained_trap_enable(fine_grained_trap_enable),
  .fine_grained_read_trap(fine_grained_read_trap),
  .fine_grained_write_trap(fine_grained_write_trap), .sysreg_ack(sysreg_ack),
  .sysreg_rdata(sysreg_rdata), .sysreg_undef(sysreg_undef), .sysreg_trap(sysreg_trap),
  .sysreg_trap_level(sysreg_trap_level));

// *** test/tb_top.sv ***
// Self-checking bench for the selected error status register
`timescale 1ns/100ps
module tb_top;
  logic mclk, reset, rq, wr, ack, und, trp, he, ht, mt, fe, fr, fw;
  logic [0:0] sel;
  logic [1:0] op0, lv, tl, ev_v, ue, de, ce, tr, rp, sy;
  logic [2:0] op1, op2;
  logic [3:0] crn, crm;
  logic [5:0] tc;
  logic [9:0] cds;
  logic [63:0] wd, rd;
  logic [63:0] m [2];
  logic [4:0] codes [7] = '{5'h00, 5'h02, 5'h06, 5'h07, 5'h08, 5'h12, 5'h15};
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 62279;
  logic [31:0] r;
  ers_status u_ers_status (.mclk(mclk), .reset(reset), .record_select(sel), .sysreg_req(rq),
    .sysreg_write(wr), .sysreg_op0(op0), .sysreg_op1(op1), .sysreg_crn(crn), .sysreg_crm(crm),
    .sysreg_op2(op2), .sysreg_wdata(wd), .level(lv), .hyp_enabled(he),
    .hyp_error_register_trap(ht), .mon_error_register_trap(mt), .fine_grained_trap_enable(fe),
    .fine_grained_read_trap(fr), .fine_grained_write_trap(fw), .err_event(ev_v),
    .err_uncorrected(ue), .err_deferred(de), .err_corrected(ce), .err_transient(tr),
    .err_reported(rp), .err_syndrome(sy), .err_code(cds), .sysreg_ack(ack), .sysreg_rdata(rd),
    .sysreg_undef(und), .sysreg_trap(trp), .sysreg_trap_level(tl), .sysreg_trap_class(tc));
  // Free-running 250 MHz clock
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Write-one-to-clear effect on a modelled record word
  function automatic logic [63:0] w1c(input logic [63:0] s, logic [63:0] w);
    s[30:26] = s[30:26] & ~w[30:26];
    s[23] = s[23] & ~w[23];
    if (w[25:24] != 2'h0) s[25:24] = 2'h0;
    if (w[30]) s[4:0] = 5'h00;
    return s;
  endfunction
  // New error on a record; q is {ue, de, ce, transient, reported, syndrome}
  function automatic logic [63:0] adde(input logic [63:0] s, logic [4:0] cd, logic [5:0] q);
    if (s[30]) s[27] = 1'h1;
    else s[4:0] = cd;
    s[30] = 1'h1;
    s[29] = s[29] | q[5];
    s[23] = s[23] | q[4];
    s[28] = s[28] | q[1];
    s[26] = s[26] | q[0];
    if (q[3]) s[25:24] = (q[2] && s[25:24] != 2'h2) ? 2'h1 : 2'h2;
    return s;
  endfunction
  // Expected {undefined, trap, trap level}; t is {he, ht, mt, fe, fr, fw}
  function automatic logic [3:0] xo(input logic [1:0] l, logic w, logic [5:0] t);
    if (l == 2'h0) return 4'h8;
    if (l == 2'h1 && t[5] && (t[4] || t[2] && (w ? t[0] : t[1]))) return 4'h6;
    if (l != 2'h3 && t[3]) return 4'h7;
    return 4'h0;
  endfunction
  task automatic chk(input string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Access driven at the next edge and taken at the one after; answer sampled half a cycle later, on the falling edge
  task automatic acc(input logic s, logic [1:0] l, logic w, logic [63:0] d, logic [5:0] t);
    logic [3:0] eo;
    logic [3:0] so;
    logic [63:0] er;
    eo = xo(l, w, t);
    er = (eo == 4'h0 && !w) ? m[s] : 64'h0;
    if (eo == 4'h0 && w) m[s] = w1c(m[s], d);
    @(posedge mclk);
    {he, ht, mt, fe, fr, fw} <= t;
    sel <= s;
    lv <= l;
    wr <= w;
    wd <= d;
    rq <= 1'h1;
    @(posedge mclk);
    rq <= 1'h0;
    @(negedge mclk);
    so = {und, trp, trp ? tl : 2'h0};
    chk("ack", {63'h0, ack}, 64'h1);
    chk("outcome", {60'h0, so}, {60'h0, eo});
    chk("trap_class", {58'h0, tc}, {58'h0, eo[2] ? 6'h18 : 6'h00});
    chk("rdata", rd, er);
  endtask
  // One error pulse, with an optional clearing write on the same edge
  task automatic ev(input logic s, logic [4:0] cd, logic [5:0] q, logic [63:0] d);
    if (d != 64'h0) m[s] = w1c(m[s], d);
    m[s] = adde(m[s], cd, q);
    @(posedge mclk);
    ev_v <= 2'h1 << s;
    {ue, de, ce} <= {{2{q[5]}}, {2{q[4]}}, {2{q[3]}}};
    {tr, rp, sy} <= {{2{q[2]}}, {2{q[1]}}, {2{q[0]}}};
    cds <= {cd, cd};
    {sel, lv, wr, wd, rq} <= {s, 2'h3, 1'h1, d, d != 64'h0};
    @(posedge mclk);
    ev_v <= 2'h0;
    rq <= 1'h0;
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog far beyond the expected run length
  initial begin
    #80000;
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence: reset, codes, overflow, same-edge clear, traps, random, cold reset
  initial begin
    {reset, rq, wr, he, ht, mt, fe, fr, fw, sel, ev_v, ue, de, ce, tr, rp, sy} = 24'h800000;
    {op0, op1, crn, crm, op2, lv, cds, wd} = {16'hc2a2, 2'h3, 10'h0, 64'h0};
    m[0] = 64'h0;
    m[1] = 64'h0;
    repeat (20) @(posedge mclk);
    reset <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      acc(i[0], 2'h3, 1'h0, 64'h0, 6'h0);
      ev(i[0], codes[i], 6'(i * 9), 64'h0);
      acc(i[0], 2'h3, 1'h0, 64'h0, 6'h0);
      acc(i[0], 2'h3, 1'h1, 64'hffff_ffff_ffff_ffff, 6'h0);
    end
    ev(1'h0, 5'h06, 6'h0c, 64'h0);
    ev(1'h0, 5'h12, 6'h08, 64'h0);
    acc(1'h0, 2'h3, 1'h1, 64'h0, 6'h0);
    ev(1'h0, 5'h15, 6'h10, 64'h0080_0000);
    acc(1'h0, 2'h3, 1'h0, 64'h0, 6'h0);
    for (int i = 0; i < 512; i++) acc(i[3], i[1:0], i[2], 64'h0, i[8:3]);
    @(posedge mclk);
    {op2, rq} <= {3'h1, 1'h1};
    @(posedge mclk);
    {op2, rq} <= {3'h2, 1'h0};
    @(negedge mclk);
    chk("miss", {63'h0, ack}, 64'h0);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      if (r[0]) ev(r[1], codes[r[4:2] % 7], r[10:5], 64'h0);
      else acc(r[1], r[12:11], r[13], {$random(seed), $random(seed)}, r[19:14] & {6{r[20]}});
    end
    @(posedge mclk);
    reset <= 1'h1;
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    m[0] = 64'h0;
    m[1] = 64'h0;
    acc(1'h0, 2'h3, 1'h0, 64'h0, 6'h0);
    acc(1'h1, 2'h3, 1'h0, 64'h0, 6'h0);
    tally_and_finish();
  end
endmodule
